// *** design/apm_map.vh ***
`ifndef APM_MAP_VH
`define APM_MAP_VH

// Serial word layout
`define APM_ADDR_W 6
`define APM_DATA_W 8
`define APM_WORD_BITS 4'he
`define APM_READ_BIT 12
`define APM_OUT_BITS 4'h8

// Register addresses
`define APM_ADDR_SETUP1 6'h01
`define APM_ADDR_SETUP3 6'h03
`define APM_ADDR_SWRESET 6'h04
`define APM_ADDR_REVISION 6'h27

// Test page commands, written to the first setup register address
`define APM_TEST_ENTER 8'ha3
`define APM_TEST_EXIT 8'h23

// First setup register fields
`define APM_EN_BIT 0
`define APM_DBL_SAMPLE_BIT 1
`define APM_MODE3_BIT 6

// Reset values
`define APM_RST_SETUP1 8'h03
`define APM_RST_SETUP3 8'h13
`define APM_RST_LED_DAC 8'h20
`define APM_RST_SETUP8 8'hc0
`define APM_RST_SETUP10 8'he4
`define APM_RST_SETUP16 8'h11
`define APM_RST_SETUP17 8'h01
`define APM_RST_SETUP18 8'h10
`define APM_RST_DAC 8'h80
`define APM_RST_ZERO 8'h00

// Timing
`define APM_CLK_NS 50
`define APM_STEP_NS 2000
`define APM_STEP_CYCLES ((`APM_STEP_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)

`endif

// *** design/apm_power_mode_control.v ***
`timescale 1ns/1ps
`include "apm_map.vh"
// Behaviour
// - Internal reset holds until digital rail good
// - Supplies and references good: enable, ordered power-up
// - Enable bit low powers off, high on
// - Registers and serial port survive power-down
// - LED rail loss keeps all configuration
// - A3 to address 01 enters test page
// - Test page read returns revision upper bits
// - 23 to address 01 leaves test page
// - Write: address, data MSB first, enable pulse
// - Read: bit four set, data out falling
module apm_power_mode_control #(
	parameter STEP_CYCLES = `APM_STEP_CYCLES,
	parameter [6:0] REVISION = 7'h2a // Arbitrary value
) (
	input wire mclk,
	input wire rst,
	input wire sck,
	input wire sdi,
	input wire sen,
	input wire digital_supply_rail_ok,
	input wire led_drive_supply_rail_ok,
	input wire front_end_supply_rail_ok,
	input wire reference_ok,
	input wire pixel_sync_strobe,
	output wire sdo,
	output wire sdo_oe,
	output reg por_hold_r,
	output reg ldo_ref_en_r,
	output reg system_enable_r,
	output reg [2:0] power_stage_r,
	output reg device_on_r,
	output reg test_mode_r,
	output reg correlated_double_sampling_r,
	output reg max_speed_mode_r,
	output reg [7:0] pixel_ratio_r,
	output reg ratio_fault_r
);
////////////////////////////////////////////////////////////////////////////////
localparam ST_OFF = 3'b001;
localparam ST_RAMP = 3'b010;
localparam ST_ON = 3'b100;
localparam NSYNC = 5;

function [7:0] reset_value;
	input [4:0] idx;
	begin
		case (idx)
			5'h01: reset_value = `APM_RST_SETUP1;
			5'h03: reset_value = `APM_RST_SETUP3;
			5'h06, 5'h07, 5'h08: reset_value = `APM_RST_LED_DAC;
			5'h09: reset_value = `APM_RST_SETUP8;
			5'h0b: reset_value = `APM_RST_SETUP10;
			5'h10, 5'h11, 5'h12, 5'h13: reset_value = `APM_RST_DAC;
			5'h15: reset_value = `APM_RST_SETUP16;
			5'h16: reset_value = `APM_RST_SETUP17;
			5'h17: reset_value = `APM_RST_SETUP18;
			default: reset_value = `APM_RST_ZERO;
		endcase
	end
endfunction

// Bit four only selects read, so it drops out of the index
function [4:0] reg_index;
	input [5:0] addr;
	begin
		reg_index = {addr[5], addr[3:0]};
	end
endfunction

function ratio_ok;
	input mode3;
	input dbl;
	input [7:0] ratio;
	begin
		if (mode3) begin
			ratio_ok = (ratio == 8'h02) && !dbl;
		end else begin
			ratio_ok = (ratio == 8'h03) || ((ratio >= 8'h04) && !ratio[0]);
		end
	end
endfunction
////////////////////////////////////////////////////////////////////////////////
wire [NSYNC-1:0] pin_sync;
wire [NSYNC-1:0] pin_raw = {pixel_sync_strobe, reference_ok, front_end_supply_rail_ok,
	led_drive_supply_rail_ok, digital_supply_rail_ok};

genvar gi;
generate
	for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
		// One flop pair per pin keeps every flop singly driven
		reg s1_r;
		reg s2_r;
		always @(posedge mclk) begin
			if (rst) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
			end else begin
				s1_r <= pin_raw[gi];
				s2_r <= s1_r;
			end
		end
		assign pin_sync[gi] = s2_r;
	end
endgenerate

wire digital_rail_ok_s = pin_sync[0];
wire led_rail_ok_s = pin_sync[1];
wire front_end_rail_ok_s = pin_sync[2];
wire ref_ok_s = pin_sync[3];
wire strobe_s = pin_sync[4];
wire por = rst | ~digital_rail_ok_s;
////////////////////////////////////////////////////////////////////////////////
wire wr_stb;
wire rd_stb;
wire [5:0] bus_addr;
wire [7:0] bus_data;
reg [7:0] regs_r [0:31];
wire [7:0] rd_data = test_mode_r ? {REVISION, 1'b0} : regs_r[reg_index(bus_addr)];

apm_serial_port u_port (
	.mclk(mclk),
	.rst(rst),
	.sck_pin(sck),
	.sdi_pin(sdi),
	.sen_pin(sen),
	.rd_data(rd_data),
	.wr_stb_r(wr_stb),
	.rd_stb_r(rd_stb),
	.addr_r(bus_addr),
	.data_r(bus_data),
	.sdo_r(sdo),
	.sdo_oe_r(sdo_oe)
);
////////////////////////////////////////////////////////////////////////////////
// Reset, digital rail loss or a write to the software reset address outside test page clears configuration; only reset and rail loss also clear power state
integer i;
always @(posedge mclk) begin
	if (por) begin
		for (i = 0; i < 32; i = i + 1) begin
			regs_r[i] <= reset_value(i[4:0]);
		end
		test_mode_r <= 1'b0;
	end else if (wr_stb) begin
		if (test_mode_r) begin
			if (bus_addr == `APM_ADDR_SETUP1 && bus_data == `APM_TEST_EXIT) begin
				test_mode_r <= 1'b0;
			end
		end else if (bus_addr == `APM_ADDR_SETUP1 && bus_data == `APM_TEST_ENTER) begin
			test_mode_r <= 1'b1;
		end else if (bus_addr == `APM_ADDR_SWRESET) begin
			for (i = 0; i < 32; i = i + 1) begin
				regs_r[i] <= reset_value(i[4:0]);
			end
		end else begin
			regs_r[reg_index(bus_addr)] <= bus_data;
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
wire [7:0] setup1 = regs_r[reg_index(`APM_ADDR_SETUP1)];
wire en_bit = setup1[`APM_EN_BIT];
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [15:0] step_cnt_r;
wire step_done = (step_cnt_r == 16'h0000);
wire go = en_bit & system_enable_r;

always @* begin
	state_nxt = state_r;
	case (state_r)
		ST_OFF: begin
			if (go) begin
				state_nxt = ST_RAMP;
			end
		end
		ST_RAMP: begin
			if (!go) begin
				state_nxt = ST_OFF;
			end else if (step_done && power_stage_r[2]) begin
				state_nxt = ST_ON;
			end
		end
		ST_ON: begin
			if (!go) begin
				state_nxt = ST_OFF;
			end
		end
		default: state_nxt = ST_OFF;
	endcase
end

always @(posedge mclk) begin
	if (por) begin
		state_r <= ST_OFF;
		step_cnt_r <= 16'h0000;
		power_stage_r <= 3'h0;
		device_on_r <= 1'b0;
		por_hold_r <= 1'b1;
		ldo_ref_en_r <= 1'b0;
		system_enable_r <= 1'b0;
	end else begin
		state_r <= state_nxt;
		por_hold_r <= 1'b0;
		ldo_ref_en_r <= led_rail_ok_s;
		system_enable_r <= led_rail_ok_s & front_end_rail_ok_s & ref_ok_s;
		device_on_r <= (state_nxt == ST_ON);
		if (state_nxt != ST_RAMP && state_nxt != ST_ON) begin
			power_stage_r <= 3'h0;
			step_cnt_r <= STEP_CYCLES[15:0] - 16'h0001;
		end else if (state_r == ST_RAMP && step_done && !power_stage_r[2]) begin
			// One domain per step limits inrush
			power_stage_r <= {power_stage_r[1:0], 1'b1};
			step_cnt_r <= STEP_CYCLES[15:0] - 16'h0001;
		end else if (!step_done) begin
			step_cnt_r <= step_cnt_r - 16'h0001;
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
// Ratio is measured after the synchroniser, so spacing is exact
reg strobe_prev_r;
reg [7:0] ratio_cnt_r;
always @(posedge mclk) begin
	if (rst) begin
		strobe_prev_r <= 1'b0;
		ratio_cnt_r <= 8'h00;
		pixel_ratio_r <= 8'h00;
		ratio_fault_r <= 1'b0;
		correlated_double_sampling_r <= 1'b0;
		max_speed_mode_r <= 1'b0;
	end else begin
		strobe_prev_r <= strobe_s;
		correlated_double_sampling_r <= setup1[`APM_DBL_SAMPLE_BIT];
		max_speed_mode_r <= setup1[`APM_MODE3_BIT];
		if (strobe_s && !strobe_prev_r) begin
			ratio_cnt_r <= 8'h01;
			pixel_ratio_r <= ratio_cnt_r;
		end else if (ratio_cnt_r != 8'hff) begin
			ratio_cnt_r <= ratio_cnt_r + 8'h01;
		end
		ratio_fault_r <= device_on_r && (pixel_ratio_r != 8'h00) &&
			!ratio_ok(max_speed_mode_r, correlated_double_sampling_r, pixel_ratio_r);
	end
end

endmodule

// *** design/apm_serial_port.v ***
`timescale 1ns/1ps
`include "apm_map.vh"
module apm_serial_port (
	input wire mclk,
	input wire rst,
	input wire sck_pin,
	input wire sdi_pin,
	input wire sen_pin,
	input wire [7:0] rd_data,
	output reg wr_stb_r,
	output reg rd_stb_r,
	output reg [5:0] addr_r,
	output reg [7:0] data_r,
	output reg sdo_r,
	output reg sdo_oe_r
);
////////////////////////////////////////////////////////////////////////////////
reg [2:0] sync1_r;
reg [2:0] sync2_r;
reg [1:0] prev_r;
reg [13:0] shift_r;
reg [3:0] cnt_r;
reg load_r;
reg [7:0] out_r;
reg [3:0] out_cnt_r;
wire sck_rise = sync2_r[0] & ~prev_r[0];
wire sck_fall = ~sync2_r[0] & prev_r[0];
wire sen_rise = sync2_r[2] & ~prev_r[1];
////////////////////////////////////////////////////////////////////////////////
always @(posedge mclk) begin
	if (rst) begin
		sync1_r <= 3'h0;
		sync2_r <= 3'h0;
		prev_r <= 2'h0;
	end else begin
		sync1_r <= {sen_pin, sdi_pin, sck_pin};
		sync2_r <= sync1_r;
		prev_r <= {sync2_r[2], sync2_r[0]};
	end
end
////////////////////////////////////////////////////////////////////////////////
// Inputs stay live in power-down so the port can always be written
always @(posedge mclk) begin
	if (rst) begin
		shift_r <= 14'h0000;
		cnt_r <= 4'h0;
		wr_stb_r <= 1'b0;
		rd_stb_r <= 1'b0;
		addr_r <= 6'h00;
		data_r <= 8'h00;
	end else begin
		wr_stb_r <= 1'b0;
		rd_stb_r <= 1'b0;
		if (sen_rise) begin
			cnt_r <= 4'h0;
			if (cnt_r == `APM_WORD_BITS) begin
				addr_r <= shift_r[13:8];
				data_r <= shift_r[7:0];
				rd_stb_r <= shift_r[`APM_READ_BIT];
				wr_stb_r <= ~shift_r[`APM_READ_BIT];
			end
		end else if (sck_rise) begin
			shift_r <= {shift_r[12:0], sync2_r[1]};
			if (cnt_r != `APM_WORD_BITS) begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
// Read data leaves MSB first, next word may shift in meanwhile
always @(posedge mclk) begin
	if (rst) begin
		load_r <= 1'b0;
		out_r <= 8'h00;
		out_cnt_r <= 4'h0;
		sdo_r <= 1'b0;
		sdo_oe_r <= 1'b0;
	end else begin
		load_r <= rd_stb_r;
		if (load_r) begin
			out_r <= rd_data;
			out_cnt_r <= `APM_OUT_BITS;
			sdo_oe_r <= 1'b1;
		end else if (sck_fall) begin
			if (out_cnt_r != 4'h0) begin
				sdo_r <= out_r[7];
				out_r <= {out_r[6:0], 1'b0};
				out_cnt_r <= out_cnt_r - 4'h1;
			end else begin
				sdo_oe_r <= 1'b0;
			end
		end
	end
end

endmodule

// *** testbench/apm_host_model.sv ***
`timescale 1ns/1ps
module apm_host_model (
	input wire mclk,
	output reg sck,
	output reg sdi,
	output reg sen,
	input wire sdo
);
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
		sen = 1'b0;
	end
	// Clock idles low; released data shows the inverse so stale bits never pass
	task xfer(input [5:0] a, input [7:0] d, output [7:0] q);
		reg [13:0] w;
		integer i;
		begin
			w = {a, d};
			q = 8'h00;
			@(negedge mclk);
			for (i = 13; i >= 0; i = i - 1) begin
				sdi = w[i];
				#200;
				sck = 1'b1;
				#200;
				sck = 1'b0;
			end
			sdi = ~w[0];
			sen = 1'b1;
			#200;
			sen = 1'b0;
			#400;
			if (a[4]) begin
				for (i = 7; i >= 0; i = i - 1) begin
					sck = 1'b1;
					#200;
					sck = 1'b0;
					#200;
					q[i] = sdo;
				end
				sck = 1'b1;
				#200;
				sck = 1'b0;
				#200;
			end
		end
	endtask
endmodule

// *** testbench/apm_power_mode_control_chk.sv ***
`timescale 1ns/1ps
module apm_power_mode_control_chk (
	input wire mclk,
	input wire rst,
	input wire sdo_oe,
	input wire por_hold_r,
	input wire system_enable_r,
	input wire [2:0] power_stage_r,
	input wire device_on_r,
	input wire test_mode_r,
	input wire correlated_double_sampling_r,
	input wire max_speed_mode_r,
	input wire [7:0] pixel_ratio_r,
	input wire ratio_fault_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_rst_por_hold: assert property (disable iff (1'b0) rst |=> por_hold_r && !device_on_r)
		else $error("por hold missing in reset");
	a_por_stage_off: assert property (por_hold_r [*2] |-> power_stage_r == 3'b000 && !device_on_r)
		else $error("powered while por holds");
	a_stage_thermo: assert property (power_stage_r inside {3'b000, 3'b001, 3'b011, 3'b111})
		else $error("power stage out of order");
	a_on_full_stage: assert property (device_on_r |-> power_stage_r == 3'b111)
		else $error("on without all stages");
	a_off_without_enable: assert property (!system_enable_r [*3] |-> !device_on_r)
		else $error("on without system enable");
	a_read_oe_holds: assert property ($rose(sdo_oe) |=> sdo_oe [*8])
		else $error("read data dropped early");
	a_test_keeps_setup: assert property (test_mode_r && $past(test_mode_r) |->
		$stable(correlated_double_sampling_r) && $stable(max_speed_mode_r))
		else $error("setup changed in test page");
	a_mode3_ratio_bad: assert property ((device_on_r && max_speed_mode_r && pixel_ratio_r == 8'h03) [*2]
		|-> ratio_fault_r)
		else $error("bad ratio not flagged");
	a_fault_needs_on: assert property (!device_on_r [*2] |-> !ratio_fault_r)
		else $error("fault while off");
endmodule
////////////////////////////////////////////////////////////////
bind apm_power_mode_control apm_power_mode_control_chk chk (.mclk, .rst, .sdo_oe, .por_hold_r, .system_enable_r,
	.power_stage_r, .device_on_r, .test_mode_r, .correlated_double_sampling_r, .max_speed_mode_r, .pixel_ratio_r,
	.ratio_fault_r);

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`include "apm_map.vh"
module tb_top;
	localparam [6:0] REV = 7'h55; // Arbitrary value
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg dig_ok = 1'b1, led_ok = 1'b1, fe_ok = 1'b1, ref_ok = 1'b1, strobe = 1'b0;
	wire sck, sdi, sen, sdo, sdo_oe, por, ldo, sys_en, on, tmode, dsmp, mode3, fault;
	wire [2:0] stage;
	wire [7:0] ratio;
	reg [7:0] q;
	integer n_errors = 0, samples_checked = 0, ps_per = 0, ps_cnt = 0;
	always #25 mclk = ~mclk;
	always @(negedge mclk) begin
		ps_cnt <= (ps_cnt + 1 >= ps_per) ? 0 : ps_cnt + 1;
		strobe <= (ps_per != 0) && (ps_cnt == 0);
	end
	// Short power steps keep the run brief
	apm_power_mode_control #(.STEP_CYCLES(4), .REVISION(REV)) dut (.mclk(mclk), .rst(rst), .sck(sck), .sdi(sdi),
		.sen(sen), .digital_supply_rail_ok(dig_ok), .led_drive_supply_rail_ok(led_ok),
		.front_end_supply_rail_ok(fe_ok), .reference_ok(ref_ok), .pixel_sync_strobe(strobe), .sdo(sdo),
		.sdo_oe(sdo_oe), .por_hold_r(por), .ldo_ref_en_r(ldo), .system_enable_r(sys_en), .power_stage_r(stage),
		.device_on_r(on), .test_mode_r(tmode), .correlated_double_sampling_r(dsmp), .max_speed_mode_r(mode3),
		.pixel_ratio_r(ratio), .ratio_fault_r(fault));
	apm_host_model host (.mclk(mclk), .sck(sck), .sdi(sdi), .sen(sen), .sdo(sdo));
	////////////////////////////////////////////////////////////////
	task stop_test;
		begin
			$display("Checked %0d, errors %0d", samples_checked, n_errors);
			if (n_errors == 0 && samples_checked > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task check(input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wait_on(input v);
		integer k;
		begin
			k = 0;
			while (on !== v && k < 400) begin
				@(negedge mclk);
				k = k + 1;
			end
			check({7'h00, on}, {7'h00, v});
			// A used-up limit already counted as a mismatch above
			if (on !== v)
				stop_test;
		end
	endtask
	task wr(input [5:0] a, input [7:0] d);
		host.xfer(a, d, q);
	endtask
	task rd(input [5:0] a, input [7:0] exp);
		begin
			host.xfer(a | 6'h10, 8'h00, q);
			check(q, exp);
			check({7'h00, sdo_oe}, 8'h00);
		end
	endtask
	task mode(input [7:0] v, input integer r, input f);
		begin
			wr(`APM_ADDR_SETUP1, v);
			ps_per = r;
			repeat (8 * r + 10) @(negedge mclk);
			check(ratio, r[7:0]);
			check({7'h00, fault}, {7'h00, f});
			check({6'h00, mode3, dsmp}, {6'h00, v[6], v[1]});
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge mclk);
		check({7'h00, por}, 8'h01);
		@(negedge mclk);
		rst = 1'b0;
		wait_on(1'b1);
		check({5'h00, stage}, 8'h07);
		check({6'h00, ldo, sys_en}, 8'h03);
		dig_ok = 1'b0;
		repeat (6) @(negedge mclk);
		check({6'h00, por, on}, 8'h02);
		dig_ok = 1'b1;
		wait_on(1'b1);
		wr(`APM_ADDR_SETUP1, 8'h02);
		wr(`APM_ADDR_SETUP1, 8'h03);
		$display("Test power-up done");
		wr(`APM_ADDR_SETUP3, 8'h03);
		wr(`APM_ADDR_SETUP1, 8'h0e);
		wait_on(1'b0);
		rd(`APM_ADDR_SETUP3, 8'h03);
		rd(`APM_ADDR_SETUP1, 8'h0e);
		wr(`APM_ADDR_SETUP1, 8'h0f);
		wait_on(1'b1);
		led_ok = 1'b0;
		repeat (10) @(negedge mclk);
		check({5'h00, ldo, sys_en, on}, 8'h00);
		led_ok = 1'b1;
		rd(`APM_ADDR_SETUP1, 8'h0f);
		rd(`APM_ADDR_SETUP3, 8'h03);
		wait_on(1'b1);
		$display("Test power-down done");
		mode(8'h0f, 4, 1'b0);
		mode(8'h0f, 3, 1'b0);
		mode(8'h0d, 3, 1'b0);
		mode(8'h0d, 2, 1'b1);
		mode(8'h4d, 3, 1'b1);
		mode(8'h4d, 2, 1'b0);
		$display("Test modes done");
		wr(`APM_ADDR_SETUP1, `APM_TEST_ENTER);
		check({7'h00, tmode}, 8'h01);
		wr(6'h05, 8'hff);
		wr(`APM_ADDR_SETUP1, 8'h0f);
		host.xfer(`APM_ADDR_REVISION | 6'h10, 8'h00, q);
		check({q[7:1], 1'b0}, {REV, 1'b0});
		rd(6'h02, {REV, 1'b0});
		wr(`APM_ADDR_SETUP1, `APM_TEST_EXIT);
		check({7'h00, tmode}, 8'h00);
		rd(`APM_ADDR_SETUP1, 8'h4d);
		rd(6'h05, 8'h00);
		wr(`APM_ADDR_SWRESET, 8'h00);
		rd(`APM_ADDR_SETUP3, `APM_RST_SETUP3);
		$display("Test revision done");
		stop_test;
	end
endmodule
